//--- verilog/mbaoc_ctrl.sv
// alignment sequencer, divided outputs and output state control behind an apb slave
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "mbaoc_defs.svh"

// Overview of operation
// - divided outputs stretch periods by one input period until phase matches
// - one sync rising edge with request set starts alignment
// - divide-by-one outputs run normally during alignment
// - enabled powered sync outputs in sync mode keep passing the sync input during alignment
// - after alignment all outputs rise on one common input clock edge
// - alignment finishes within forty-eight input clock periods
// - request bit clears itself when alignment is achieved
// - alignment repeats whenever software sets the request again
// - with request zero the sync input is simply buffered to outputs
// - power down forces an output off whatever else is set
// - powered but disabled output holds true leg low, complement high
// - lvds amplitudes 350 or 750, lvpecl 350, 750 or 1000
// - sync outputs share clock coding; lvds bias bit selects idle behaviour
// - idle select zero: idle low, toggle for pulses, return to low
// - idle select one: idle at crosspoint, toggle for pulses, return there
module mbaoc_ctrl
    import mbaoc_pkg::*;
(
    input  wire logic        mclk,       // input clock, 100 mhz
    input  wire logic        resetn,     // synchronous reset, active low
    input  wire logic [7:0]  paddr,      // apb byte address
    input  wire logic        psel,       // apb select
    input  wire logic        penable,    // apb access phase
    input  wire logic        pwrite,     // apb direction, 1 = write
    input  wire logic [31:0] pwdata,     // apb write data
    output logic      [31:0] prdata,     // apb read data
    output logic             pready,     // apb ready
    output logic             pslverr,    // apb error on unmapped address
    input  wire logic        sync_in,    // sync pulse input pin
    output logic      [3:0]  qclk_p,     // divided clock true legs
    output logic      [3:0]  qclk_n,     // divided clock complement legs
    output logic      [3:0]  qclk_on,    // divided clock outputs powered
    output logic      [3:0]  qclk_style, // 1 = lvpecl, 0 = lvds
    output logic      [7:0]  qclk_lvl,   // amplitude 0=350 1=750 2=1000 mv
    output logic      [3:0]  qref_p,     // sync output true legs
    output logic      [3:0]  qref_n,     // sync output complement legs
    output logic      [3:0]  qref_on,    // sync outputs powered
    output logic      [3:0]  qref_mid,   // both legs at crosspoint level
    output logic      [3:0]  qref_style, // 1 = lvpecl, 0 = lvds
    output logic      [7:0]  qref_lvl,   // amplitude code as for clocks
    output logic             align_busy  // alignment in progress
);

    mbaoc_state_t s;
    mbaoc_state_t next_s;

    // divider code to ratio; unknown codes fall back to bypass
    function automatic logic [4:0] ratio_of(input logic [3:0] code);
        unique case (code)
            4'h1:    ratio_of = 5'd2;
            4'h2:    ratio_of = 5'd3;
            4'h3:    ratio_of = 5'd4;
            4'h4:    ratio_of = 5'd6;
            4'h5:    ratio_of = 5'd8;
            4'h6:    ratio_of = 5'd12;
            4'h7:    ratio_of = 5'd16;
            4'h8:    ratio_of = 5'd24;
            default: ratio_of = 5'd1;
        endcase
    endfunction : ratio_of

    // amplitude code: lvds has only two steps, lvpecl saturates at 1000 mv
    function automatic logic [1:0] amp_of(input logic style, input logic [1:0] amp);
        if (!style) begin
            amp_of = {1'b0, amp[0]};
        end else begin
            amp_of = amp[1] ? 2'h2 : amp;
        end
    endfunction : amp_of

    // modulo-ratio increment shared by counters and alignment targets
    function automatic logic [4:0] step_of(input logic [4:0] v, input logic [4:0] r);
        step_of = (v + 5'h01 >= r) ? 5'h00 : v + 5'h01;
    endfunction : step_of

    logic       acc;
    logic       wr;
    logic       hit;
    logic       rise;
    logic       all_match;
    logic       set_req;
    logic [31:0] rd_mux;

    assign acc     = psel & penable;
    assign wr      = acc & pwrite;
    assign hit     = (paddr == `MBAOC_ADDR_CTRL) || (paddr == `MBAOC_ADDR_STATUS) ||
                     (paddr == `MBAOC_ADDR_DIV) || (paddr == `MBAOC_ADDR_CLKCFG) ||
                     (paddr == `MBAOC_ADDR_REFCFG);
    assign rise    = s.sync_ff2 & ~s.sync_prev;
    assign set_req = wr && (paddr == `MBAOC_ADDR_CTRL) && pwdata[`MBAOC_CTRL_REQ];

    // no wait states: read data is latched in setup, so pready is a plain decode
    assign pready  = acc;
    assign pslverr = acc & ~hit;
    assign prdata  = s.prdata;

    // read decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            `MBAOC_ADDR_CTRL:   rd_mux = {30'h0, s.idle_sel, s.req};
            `MBAOC_ADDR_STATUS: rd_mux = {29'h0, s.sync_ff2, s.req, s.busy};
            `MBAOC_ADDR_DIV:    rd_mux = {16'h0, s.div};
            `MBAOC_ADDR_CLKCFG: rd_mux = {12'h0, s.clkcfg};
            `MBAOC_ADDR_REFCFG: rd_mux = s.refcfg;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // all divided channels sit on the common alignment phase
    always_comb begin
        all_match = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (s.cnt[i] != s.tgt[i]) begin
                all_match = 1'b0;
            end
        end
    end

    // next-state logic for the whole block
    always_comb begin
        logic [4:0] r;
        logic       lvl;
        logic [4:0] cs;
        logic [7:0] rs;
        next_s = s;
        r      = 5'h00;
        lvl    = 1'b0;
        cs     = 5'h00;
        rs     = 8'h00;

        // only the second stage reads the first
        next_s.sync_ff1  = sync_in;
        next_s.sync_ff2  = s.sync_ff1;
        next_s.sync_prev = s.sync_ff2;

        if (psel && !penable) begin
            next_s.prdata = rd_mux;
        end
        if (wr) begin
            unique case (paddr)
                `MBAOC_ADDR_CTRL:   next_s.idle_sel = pwdata[`MBAOC_CTRL_IDLESEL];
                `MBAOC_ADDR_DIV:    next_s.div      = pwdata[15:0];
                `MBAOC_ADDR_CLKCFG: next_s.clkcfg   = pwdata[19:0];
                `MBAOC_ADDR_REFCFG: next_s.refcfg   = pwdata;
                default: ;
            endcase
        end

        // sequencer: armed edge starts, match or the bound ends
        if (!s.busy) begin
            if (s.req && rise) begin
                next_s.busy  = 1'b1;
                next_s.timer = 6'h00;
                next_s.tgt   = '0;
            end
        end else if (all_match || s.timer == 6'(`MBAOC_ALIGN_MAX_CYC - 2)) begin
            next_s.busy = 1'b0;
            next_s.req  = 1'b0;
        end else begin
            next_s.timer = s.timer + 6'h01;
        end
        // a software set wins over the auto clear and rearms
        if (set_req) begin
            next_s.req = 1'b1;
        end

        for (int i = 0; i < 4; i++) begin
            r = ratio_of(s.div[i]);
            // held counter stretches the current output period by one input period
            if (s.busy && s.cnt[i] != s.tgt[i] && s.timer != 6'(`MBAOC_ALIGN_MAX_CYC - 2)) begin
                next_s.cnt[i] = s.cnt[i];
            end else if (s.busy) begin
                next_s.cnt[i] = step_of(s.tgt[i], r);
            end else begin
                next_s.cnt[i] = step_of(s.cnt[i], r);
            end
            if (s.busy) begin
                next_s.tgt[i] = step_of(s.tgt[i], r);
            end
            if (s.busy == 1'b0 && s.req && rise) begin
                next_s.tgt[i] = 5'h00;
            end
            lvl = next_s.cnt[i] < ((r + 5'h01) >> 1);

            // divided clock output state
            cs = s.clkcfg[i*5 +: 5];
            if (cs[`MBAOC_F_PD]) begin
                next_s.qclk_on[i] = 1'b0;
                next_s.qclk_p[i]  = 1'b0;
                next_s.qclk_n[i]  = 1'b0;
            end else if (!cs[`MBAOC_F_EN]) begin
                next_s.qclk_on[i] = 1'b1;
                next_s.qclk_p[i]  = 1'b0;
                next_s.qclk_n[i]  = 1'b1;
            end else begin
                next_s.qclk_on[i] = 1'b1;
                next_s.qclk_p[i]  = lvl;
                next_s.qclk_n[i]  = ~lvl;
            end

            // sync pulse output: clock mode follows its channel, sync mode the input
            rs = s.refcfg[i*8 +: 8];
            next_s.qref_mid[i] = 1'b0;
            if (rs[`MBAOC_F_PD]) begin
                next_s.qref_on[i] = 1'b0;
                next_s.qref_p[i]  = 1'b0;
                next_s.qref_n[i]  = 1'b0;
            end else if (!rs[`MBAOC_F_EN]) begin
                next_s.qref_on[i] = 1'b1;
                next_s.qref_p[i]  = 1'b0;
                next_s.qref_n[i]  = 1'b1;
            end else if (!rs[`MBAOC_F_SRC]) begin
                next_s.qref_on[i] = 1'b1;
                next_s.qref_p[i]  = lvl;
                next_s.qref_n[i]  = ~lvl;
            // the detected edge itself must pass, or the first pulse cycle is lost
            end else if (rs[`MBAOC_F_STYLE] || rs[`MBAOC_F_BIAS] || s.active || rise) begin
                next_s.qref_on[i] = 1'b1;
                next_s.qref_p[i]  = s.sync_ff2;
                next_s.qref_n[i]  = ~s.sync_ff2;
            end else if (s.idle_sel) begin
                next_s.qref_on[i]  = 1'b1;
                next_s.qref_p[i]   = 1'b0;
                next_s.qref_n[i]   = 1'b0;
                next_s.qref_mid[i] = 1'b1;
            end else begin
                next_s.qref_on[i] = 1'b1;
                next_s.qref_p[i]  = 1'b0;
                next_s.qref_n[i]  = 1'b1;
            end
        end

        // pulse train tracking: a long low spell returns the outputs to idle
        if (rise) begin
            next_s.active   = 1'b1;
            next_s.idle_cnt = 7'h00;
        end else if (s.active) begin
            if (s.sync_ff2) begin
                next_s.idle_cnt = 7'h00;
            end else if (s.idle_cnt == 7'(`MBAOC_SYNC_IDLE_CYC - 1)) begin
                next_s.active = 1'b0;
            end else begin
                next_s.idle_cnt = s.idle_cnt + 7'h01;
            end
        end

        if (!resetn) begin
            next_s        = '0;
            next_s.div    = `MBAOC_DIV_RESET;
            next_s.clkcfg = `MBAOC_CLKCFG_RESET;
            next_s.refcfg = `MBAOC_REFCFG_RESET;
        end
    end

    // single state register
    always_ff @(posedge mclk) begin
        s <= next_s;
    end

    // style and amplitude decode of the stored settings
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            qclk_style[i]       = s.clkcfg[i*5 + `MBAOC_F_STYLE];
            qclk_lvl[i*2 +: 2]  = amp_of(s.clkcfg[i*5 + `MBAOC_F_STYLE],
                                         s.clkcfg[i*5 + `MBAOC_F_AMP +: 2]);
            qref_style[i]       = s.refcfg[i*8 + `MBAOC_F_STYLE];
            qref_lvl[i*2 +: 2]  = amp_of(s.refcfg[i*8 + `MBAOC_F_STYLE],
                                         s.refcfg[i*8 + `MBAOC_F_AMP +: 2]);
        end
    end

    assign qclk_p     = s.qclk_p;
    assign qclk_n     = s.qclk_n;
    assign qclk_on    = s.qclk_on;
    assign qref_p     = s.qref_p;
    assign qref_n     = s.qref_n;
    assign qref_on    = s.qref_on;
    assign qref_mid   = s.qref_mid;
    assign align_busy = s.busy;

    // checks
    sequence seq_armed_edge;
        !s.busy && s.req && rise;
    endsequence

    sequence seq_align_run;
        s.busy;
    endsequence

    a_start_edge: assert property (@(posedge mclk) disable iff (!resetn)
        seq_armed_edge |=> seq_align_run) else $error("armed edge did not start");
    a_align_bound: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(s.busy) |-> ##[1:47] !s.busy) else $error("alignment too long");
    a_idle_quiet: assert property (@(posedge mclk) disable iff (!resetn)
        !s.req && !s.busy |=> !s.busy) else $error("alignment without request");
    a_req_autoclr: assert property (@(posedge mclk) disable iff (!resetn)
        $fell(s.busy) |-> !s.req || $past(set_req)) else $error("request not cleared");
    a_stretch_hold: assert property (@(posedge mclk) disable iff (!resetn)
        s.busy && s.cnt[1] != s.tgt[1] && s.timer < 6'd46 |=> $stable(s.cnt[1]))
        else $error("counter not held");
    a_div1_steady: assert property (@(posedge mclk) disable iff (!resetn)
        s.busy && s.div[0] == 4'h0 && s.clkcfg[4:3] == 2'b01 ##1 s.div[0] == 4'h0
        |=> qclk_p[0]) else $error("bypass clock disturbed");
    a_pd_off: assert property (@(posedge mclk) disable iff (!resetn)
        s.clkcfg[`MBAOC_F_PD] |=> !qclk_on[0] && !qclk_p[0] && !qclk_n[0])
        else $error("powered down output active");
    a_dis_static: assert property (@(posedge mclk) disable iff (!resetn)
        s.refcfg[4:3] == 2'b00 |=> qref_on[0] && !qref_p[0] && qref_n[0])
        else $error("disabled output not static");
    a_ref_pass: assert property (@(posedge mclk) disable iff (!resetn)
        s.refcfg[6:3] == 4'b1001 && (s.active || rise) |=> qref_p[0] == $past(s.sync_ff2))
        else $error("sync not passed");
    a_mid_idle: assert property (@(posedge mclk) disable iff (!resetn)
        s.refcfg[6:2] == 5'b10010 && s.idle_sel && !s.active && !rise |=> qref_mid[0])
        else $error("crosspoint idle missing");
    a_clk_dis: assert property (@(posedge mclk) disable iff (!resetn)
        s.clkcfg[4:3] == 2'b00 |=> qclk_on[0] && !qclk_p[0] && qclk_n[0])
        else $error("disabled clock not static");
    a_ref_off: assert property (@(posedge mclk) disable iff (!resetn)
        s.refcfg[`MBAOC_F_PD] |=> !qref_on[0] && !qref_p[0] && !qref_n[0])
        else $error("powered down sync output active");
    // an armed request must survive until an edge consumes it
    a_req_hold: assert property (@(posedge mclk) disable iff (!resetn)
        !s.busy && s.req && !rise |=> s.req) else $error("request lost while armed");

endmodule : mbaoc_ctrl

//--- verilog/mbaoc_defs.svh
// register map, field positions, reset values and timing counts of the align/output block
`ifndef MBAOC_DEFS_SVH
`define MBAOC_DEFS_SVH

`define MBAOC_ADDR_CTRL      8'h00
`define MBAOC_ADDR_STATUS    8'h04
`define MBAOC_ADDR_DIV       8'h08
`define MBAOC_ADDR_CLKCFG    8'h0c
`define MBAOC_ADDR_REFCFG    8'h10

`define MBAOC_CTRL_REQ       0
`define MBAOC_CTRL_IDLESEL   1

`define MBAOC_F_AMP          0
`define MBAOC_F_STYLE        2
`define MBAOC_F_EN           3
`define MBAOC_F_PD           4
`define MBAOC_F_BIAS         5
`define MBAOC_F_SRC          6

`define MBAOC_DIV_RESET      16'h0000
`define MBAOC_CLKCFG_RESET   20'h42108
`define MBAOC_REFCFG_RESET   32'h0000_0000

`define MBAOC_MCLK_PERIOD_NS 10
`define MBAOC_ALIGN_MAX_NS   480
`define MBAOC_ALIGN_MAX_CYC  (`MBAOC_ALIGN_MAX_NS / `MBAOC_MCLK_PERIOD_NS)
`define MBAOC_SYNC_IDLE_NS   640
`define MBAOC_SYNC_IDLE_CYC  (`MBAOC_SYNC_IDLE_NS / `MBAOC_MCLK_PERIOD_NS)

`endif

//--- verilog/mbaoc_pkg.sv
// types of the multi buffer align / output control block
package mbaoc_pkg;

    typedef struct packed {
        logic            sync_ff1;    // synchroniser stage one
        logic            sync_ff2;    // synchroniser stage two
        logic            sync_prev;   // edge detector history
        logic            req;         // multi_device_align_request
        logic            idle_sel;    // global idle level select
        logic            busy;        // alignment running
        logic [5:0]      timer;       // cycles since the common edge
        logic [3:0][3:0] div;         // divider codes
        logic [3:0][4:0] cnt;         // divider counters
        logic [3:0][4:0] tgt;         // common alignment phase per channel
        logic [19:0]     clkcfg;      // divided_clock_output settings
        logic [31:0]     refcfg;      // sync_pulse_output settings
        logic            active;      // sync pulse train in progress
        logic [6:0]      idle_cnt;    // low cycles since last pulse
        logic [31:0]     prdata;      // latched read data
        logic [3:0]      qclk_p;
        logic [3:0]      qclk_n;
        logic [3:0]      qclk_on;
        logic [3:0]      qref_p;
        logic [3:0]      qref_n;
        logic [3:0]      qref_on;
        logic [3:0]      qref_mid;
    } mbaoc_state_t;

endpackage : mbaoc_pkg

//--- testbench/mbaoc_sync_gen.sv
// partner model: clock generator side that drives the sync pulse pin
`timescale 1ns/1ps
module mbaoc_sync_gen #(
    parameter int HIGH_CYC = 24  // pulse width in mclk cycles
) (
    input  wire logic mclk,      // shared input clock, runs throughout
    input  wire logic fire,      // bench asks for one sync pulse
    output logic      sync_in    // sync pulse towards the block
);
    // one pulse per request; width and spacing stay at least as long as any divided period
    initial sync_in = 1'b0;
    // rising edge lands just after one edge, ahead of the next shared clock edge
    always begin
        @(posedge mclk iff fire);
        #1;
        sync_in = 1'b1;
        repeat (HIGH_CYC) @(posedge mclk);
        #1;
        sync_in = 1'b0;
    end
endmodule : mbaoc_sync_gen

//--- testbench/multi_buffer_align_output_ctrl_tb_top.sv
// self-checking bench: apb registers, output states, sync idle handling, alignment
`timescale 1ns/1ps
`include "mbaoc_defs.svh"
module multi_buffer_align_output_ctrl_tb_top;
    logic        mclk;
    logic        resetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sync_in;
    logic        fire;
    logic [3:0]  qclk_p, qclk_n, qclk_on, qclk_style;
    logic [3:0]  qref_p, qref_n, qref_on, qref_mid, qref_style;
    logic [7:0]  qclk_lvl, qref_lvl;
    logic        align_busy;
    int          num_errors = 0;
    int          cmp_count = 0;

    mbaoc_ctrl u_dut (.mclk(mclk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sync_in(sync_in), .qclk_p(qclk_p),
        .qclk_n(qclk_n), .qclk_on(qclk_on), .qclk_style(qclk_style), .qclk_lvl(qclk_lvl),
        .qref_p(qref_p), .qref_n(qref_n), .qref_on(qref_on), .qref_mid(qref_mid),
        .qref_style(qref_style), .qref_lvl(qref_lvl), .align_busy(align_busy));

    mbaoc_sync_gen u_gen (.mclk(mclk), .fire(fire), .sync_in(sync_in));

    // free running 100 mhz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic stop_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // step past the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick

    // apb master: setup, then access held until pready is seen at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        e;
        apb(a, 1'b1, d, rd, e);
    endtask : wr

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        e;
        apb(a, 1'b0, 32'h0, rd, e);
        chk(name, exp, rd);
    endtask : rdchk

    // one sync pulse; the pin rises just after the edge at which this returns
    task automatic pulse();
        @(posedge mclk);
        fire <= 1'b1;
        @(posedge mclk);
        fire <= 1'b0;
    endtask : pulse

    task automatic sc_reset();
        logic [31:0] rd;
        logic        e;
        chk("clk_state", 12'hff0, {qclk_on, qclk_p, qclk_n});
        chk("ref_state", 16'hf0f0, {qref_on, qref_p, qref_n, qref_mid});
        rdchk("ctrl", `MBAOC_ADDR_CTRL, 32'h0);
        rdchk("div", `MBAOC_ADDR_DIV, 32'h0);
        rdchk("clkcfg", `MBAOC_ADDR_CLKCFG, 32'h0004_2108);
        rdchk("refcfg", `MBAOC_ADDR_REFCFG, 32'h0);
        wr(`MBAOC_ADDR_STATUS, 32'hffff_ffff);
        rdchk("status_ro", `MBAOC_ADDR_STATUS, 32'h0);
        apb(8'h20, 1'b0, 32'h0, rd, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_rd", 32'h0, rd);
    endtask : sc_reset

    // out0 lvds bias0, out1 powered down, out2 bias1, out3 disabled
    task automatic sc_sync_idle(input logic idle);
        wr(`MBAOC_ADDR_CTRL, {30'h0, idle, 1'b0});
        wr(`MBAOC_ADDR_REFCFG, 32'h4068_5848);
        tick(3);
        chk("ref_on", 4'b1101, qref_on);
        chk("ref0_idle", {idle, 1'b0, ~idle}, {qref_mid[0], qref_p[0], qref_n[0]});
        chk("ref23_idle", 6'b001001, {qref_mid[2], qref_p[2], qref_n[2], qref_mid[3], qref_p[3],
            qref_n[3]});
        pulse();
        tick(6);
        chk("ref_pulse", 9'b010010001, {qref_mid[0], qref_p[0], qref_n[0], qref_mid[2],
            qref_p[2], qref_n[2], qref_mid[3], qref_p[3], qref_n[3]});
        tick(28);
        chk("ref0_train", 3'b001, {qref_mid[0], qref_p[0], qref_n[0]});
        tick(70);
        chk("ref0_back", {idle, 1'b0, ~idle}, {qref_mid[0], qref_p[0], qref_n[0]});
    endtask : sc_sync_idle

    task automatic sc_align();
        int         n;
        logic [3:0] prev;
        logic [3:0] r;
        // phase delays live outside this block and stay at zero and four steps
        wr(`MBAOC_ADDR_DIV, 32'h0000_1830);
        wr(`MBAOC_ADDR_CTRL, 32'h3);
        rdchk("req_set", `MBAOC_ADDR_STATUS, 32'h2);
        tick(500);
        pulse();
        n = 0;
        while (align_busy !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk("busy_start", 1'b1, align_busy);
        chk("ref_align", 1'b1, qref_p[0]);
        n = 0;
        while (align_busy === 1'b1 && n < 60) begin
            chk("div1_run", 1'b1, qclk_p[0]);
            tick(1);
            n++;
        end
        chk("align_len", 1'b1, n <= 48);
        rdchk("req_clear", `MBAOC_ADDR_CTRL, 32'h2);
        prev = qclk_p;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            r = qclk_p & ~prev;
            if (r[2] === 1'b1) chk("common_edge", 3'b111, r[3:1]);
            prev = qclk_p;
        end
        pulse();
        tick(8);
        chk("no_start", 1'b0, align_busy);
        wr(`MBAOC_ADDR_CTRL, 32'h3);
        tick(500);
        pulse();
        n = 0;
        while (align_busy !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk("rearm", 1'b1, align_busy);
        tick(60);
        chk("rearm_done", 1'b0, align_busy);
    endtask : sc_align

    task automatic sc_clkcfg();
        logic [1:0] a;
        logic [1:0] e2;
        wr(`MBAOC_ADDR_CLKCFG, 32'h0004_b81e);
        tick(3);
        chk("clk_on", 4'b1110, qclk_on);
        chk("clk_dis", 2'b01, {qclk_p[1], qclk_n[1]});
        chk("clk_style", 2'b10, {qclk_style[2], qclk_style[3]});
        // every amplitude code on lvpecl out2, codes 00 and 01 on lvds out3
        for (int i = 0; i < 4; i++) begin
            a = i[1:0];
            e2 = (a == 2'b11) ? 2'b10 : a;
            wr(`MBAOC_ADDR_CLKCFG, {12'h0, 4'b0100, a[0], 3'b011, a, 10'b01000_01000});
            tick(3);
            chk("clk_lvl", {1'b0, a[0], e2}, qclk_lvl[7:4]);
        end
        // sync out1 lvpecl code 11 saturates, out0 lvds code 01
        wr(`MBAOC_ADDR_REFCFG, 32'h0000_0701);
        tick(3);
        chk("ref_lvl", 12'h209, {qref_style, qref_lvl});
    endtask : sc_clkcfg

    // watchdog: whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        stop_test();
    end

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        fire = 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        tick(2);
        sc_reset();
        sc_sync_idle(1'b0);
        sc_sync_idle(1'b1);
        sc_align();
        sc_clkcfg();
        stop_test();
    end
endmodule : multi_buffer_align_output_ctrl_tb_top
